//--- fdnp_cfg.svh
// Constants of the full-duplex nibble port: register offsets, field positions,
// reset values and port clock timing.
// Assumes inclusion by bare name from the port module.
`ifndef FDNP_CFG_SVH
`define FDNP_CFG_SVH

// Register offsets
`define FDNP_OFS_CLK_CTRL 5'h05
`define FDNP_OFS_RX_GAIN 5'h09
`define FDNP_OFS_GAIN_SRC 5'h0b
`define FDNP_OFS_TX_FMT 5'h0c
`define FDNP_OFS_RX_FMT 5'h0d
`define FDNP_OFS_DRIVE 5'h0e

// Clock control fields
`define FDNP_CLK_STOP 0
`define FDNP_CLK_INV 1
`define FDNP_CLK_OSC 2

// Port format fields, same positions for both directions
`define FDNP_FMT_TWOS 0
`define FDNP_FMT_NEG 1
`define FDNP_FMT_LSFIRST 2
`define FDNP_FMT_FIVE 3
`define FDNP_FMT_SYNCINV 4
`define FDNP_FMT_RXOFF 5

// Gain source fields and the gain register enable bit
`define FDNP_SRC_TXBUS 2
`define FDNP_SRC_SWSTROBE 3
`define FDNP_SRC_PORT_RX 5
`define FDNP_SRC_PORT_TX 6
`define FDNP_GAIN_EN 6

// Reset values
`define FDNP_RST_CLK_CTRL 8'h00
`define FDNP_RST_GAIN_SRC 8'h04
`define FDNP_RST_FMT 8'h01
`define FDNP_RST_DRIVE 8'h00
`define FDNP_RST_GAIN 6'h00

// Port clock timing: half period in ns and in system clock cycles (50 ns)
`define FDNP_CLK_PERIOD_NS 50
`define FDNP_PCLK_HALF_NS 200
`define FDNP_PCLK_HALF_CYC (`FDNP_PCLK_HALF_NS / `FDNP_CLK_PERIOD_NS)

`endif

//--- fdnp_pkg.sv
// Types shared by the full-duplex nibble port.
// Assumes fdnp_cfg.svh is in the include path.
`default_nettype none

package fdnp_pkg;
  // Serial port frame progress
  typedef enum logic [1:0] {
    FDNP_SPI_IDLE = 2'b00,
    FDNP_SPI_HEAD = 2'b01,
    FDNP_SPI_DATA = 2'b10
  } fdnp_spi_state_type;

  // Receive nibble phase
  typedef enum logic {
    FDNP_RX_FIRST = 1'b0,
    FDNP_RX_SECOND = 1'b1
  } fdnp_rx_phase_type;
endpackage : fdnp_pkg

`default_nettype wire

//--- fdnp_port.sv
// Full-duplex nibble data port with receive gain update and serial register port.
// Assumes a 20 MHz clk, synchronous active-high reset, host pins asynchronous to clk,
// and converter-side words on the clk domain.
`default_nettype none
`include "fdnp_cfg.svh"

module fdnp_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic mode_strap,
  input wire logic oscillator_input,
  output logic port_clock_out,
  input wire logic [5:0] tx_nibble,
  input wire logic tx_word_sync,
  input wire logic tx_quiet_n,
  input wire logic gain_strobe,
  input wire logic [5:0] gain_word_port,
  output logic [5:0] rx_nibble,
  output logic rx_nibble_oe,
  output logic rx_word_sync,
  output logic [9:0] tx_word,
  output logic tx_word_valid,
  output logic tx_output_enable,
  input wire logic [9:0] rx_word,
  output logic rx_word_take,
  output logic [5:0] receive_gain_amp,
  output logic [5:0] transmit_gain_amp,
  output logic low_drive,
  input wire logic spi_sclk,
  input wire logic spi_sen_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe
);
  import fdnp_pkg::*;

  // Two-flop synchronisers for every pin; stage one feeds only stage two
  logic [19:0] pin_s1_q;
  logic [19:0] pin_s2_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_s1_q <= 20'h00000;
      pin_s2_q <= 20'h00000;
    end else begin
      pin_s1_q <= {mode_strap, oscillator_input, tx_nibble, tx_word_sync, tx_quiet_n, gain_strobe,
                   gain_word_port, spi_sclk, spi_sen_n, spi_sdi};
      pin_s2_q <= pin_s1_q;
    end
  end

  logic mode_s;
  logic osc_s;
  logic [5:0] txn_s;
  logic tx_word_sync_s;
  logic quiet_s;
  logic strobe_s;
  logic [5:0] gport_s;
  logic sclk_s;
  logic sen_s;
  logic sdi_s;
  assign {mode_s, osc_s, txn_s, tx_word_sync_s, quiet_s, strobe_s, gport_s, sclk_s, sen_s, sdi_s} = pin_s2_q;

  // Configuration registers
  logic [7:0] clk_ctrl_q;
  logic [7:0] gain_src_q;
  logic [7:0] tx_fmt_q;
  logic [7:0] rx_fmt_q;
  logic [7:0] drive_q;
  logic [5:0] rx_gain_q;
  logic [5:0] tx_gain_q;
  logic gain_en_q; // Last written serial enable bit of the gain register

  // Port clock generation
  logic [2:0] div_cnt_q;
  logic div_clk_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      div_cnt_q <= 3'h0;
      div_clk_q <= 1'b0;
    end else if (div_cnt_q == 3'(`FDNP_PCLK_HALF_CYC - 1)) begin
      div_cnt_q <= 3'h0;
      div_clk_q <= ~div_clk_q; // Nibble-rate clock from the synthesizer divider
    end else begin
      div_cnt_q <= div_cnt_q + 3'h1;
    end
  end

  // Timing base is the pin-side clock: divider or buffered oscillator, then inversion
  logic pclk_d;
  logic pclk_prev_q;
  logic pclk_run;
  assign pclk_d = (clk_ctrl_q[`FDNP_CLK_OSC] ? osc_s : div_clk_q) ^ clk_ctrl_q[`FDNP_CLK_INV];
  assign pclk_run = mode_s & ~clk_ctrl_q[`FDNP_CLK_STOP];

  // Clock pin and edge tracking; a stopped clock stops both buses
  always_ff @(posedge clk) begin
    if (reset) begin
      port_clock_out <= 1'b0;
      pclk_prev_q <= 1'b0;
    end else begin
      port_clock_out <= pclk_run & pclk_d; // Held low when stopped
      pclk_prev_q <= pclk_d;
    end
  end

  logic pclk_rise;
  logic pclk_fall;
  logic tx_edge;
  logic rx_edge;
  assign pclk_rise = pclk_run & pclk_d & ~pclk_prev_q;
  assign pclk_fall = pclk_run & ~pclk_d & pclk_prev_q;
  // Transmit samples on the selected edge
  assign tx_edge = tx_fmt_q[`FDNP_FMT_NEG] ? pclk_fall : pclk_rise;
  // Receive changes on the edge opposite its validating edge
  assign rx_edge = rx_fmt_q[`FDNP_FMT_NEG] ? pclk_rise : pclk_fall;

  // Transmit nibble decode; the first level follows the sync invert bit
  logic tx_first_lvl;
  logic gain_strobe_eff;
  logic tx_gain_load;
  assign tx_first_lvl = (tx_word_sync_s == tx_fmt_q[`FDNP_FMT_SYNCINV]);
  assign gain_strobe_eff = strobe_s | gain_src_q[`FDNP_SRC_SWSTROBE];
  // Strobe high with first-level sync diverts the nibble to receive gain
  // Hosts are expected to keep the strobe low while transmitting
  assign tx_gain_load = tx_edge & gain_strobe_eff & tx_first_lvl & gain_src_q[`FDNP_SRC_TXBUS];

  // Word assembly of two nibbles
  logic [5:0] tx_first_q;
  logic tx_have_first_q;
  logic [5:0] tx_ms;
  logic [5:0] tx_ls;
  logic [9:0] tx_asm;
  always_comb begin
    tx_ms = tx_fmt_q[`FDNP_FMT_LSFIRST] ? txn_s : tx_first_q;
    tx_ls = tx_fmt_q[`FDNP_FMT_LSFIRST] ? tx_first_q : txn_s;
    if (tx_fmt_q[`FDNP_FMT_FIVE]) begin
      tx_asm = {tx_ms[5:1], tx_ls[5:1]}; // 5/5 on lines [5:1]
    end else begin
      tx_asm = {tx_ms[5:0], tx_ls[3:0]}; // 6/4 default
    end
    // Straight binary turns into the internal twos complement by the sign flip
    tx_asm[9] = tx_asm[9] ^ ~tx_fmt_q[`FDNP_FMT_TWOS];
  end

  // Transmit capture and pairing
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_first_q <= 6'h00;
      tx_have_first_q <= 1'b0; // Partial word dropped
      tx_word <= 10'h000;
      tx_word_valid <= 1'b0;
      tx_output_enable <= 1'b0;
    end else begin
      tx_word_valid <= 1'b0;
      tx_output_enable <= quiet_s & mode_s;
      if (!mode_s) begin
        tx_have_first_q <= 1'b0;
      end else if (tx_edge && !tx_gain_load) begin
        if (tx_first_lvl) begin
          // Long first level keeps refreshing the first nibble
          tx_first_q <= txn_s;
          tx_have_first_q <= 1'b1;
        end else if (tx_have_first_q) begin
          // Quiet input low feeds zeros to the filter
          tx_word <= quiet_s ? tx_asm : 10'h000;
          tx_word_valid <= 1'b1;
          tx_have_first_q <= 1'b0;
        end
      end
    end
  end

  // Receive split: nibble pair per converter word
  fdnp_rx_phase_type rx_phase_q;
  logic [5:0] rx_second_q;
  logic [9:0] rx_w;
  logic [5:0] rx_ms;
  logic [5:0] rx_ls;
  always_comb begin
    rx_w = rx_word;
    rx_w[9] = rx_word[9] ^ ~rx_fmt_q[`FDNP_FMT_TWOS];
    if (rx_fmt_q[`FDNP_FMT_FIVE]) begin
      rx_ms = {rx_w[9:5], 1'b0};
      rx_ls = {rx_w[4:0], 1'b0};
    end else begin
      rx_ms = rx_w[9:4];
      rx_ls = {2'b00, rx_w[3:0]};
    end
  end

  // Receive output driver
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_phase_q <= FDNP_RX_FIRST;
      rx_second_q <= 6'h00;
      rx_nibble <= 6'h00;
      rx_nibble_oe <= 1'b0;
      rx_word_sync <= 1'b0;
      rx_word_take <= 1'b0;
    end else begin
      rx_word_take <= 1'b0;
      rx_nibble_oe <= mode_s & ~rx_fmt_q[`FDNP_FMT_RXOFF];
      if (rx_edge) begin
        unique case (rx_phase_q)
          FDNP_RX_FIRST: begin
            // One converter word every two nibbles
            rx_word_take <= 1'b1;
            rx_nibble <= rx_fmt_q[`FDNP_FMT_LSFIRST] ? rx_ls : rx_ms;
            rx_second_q <= rx_fmt_q[`FDNP_FMT_LSFIRST] ? rx_ms : rx_ls;
            rx_word_sync <= rx_fmt_q[`FDNP_FMT_SYNCINV]; // Low for first by default
            rx_phase_q <= FDNP_RX_SECOND;
          end
          FDNP_RX_SECOND: begin
            rx_nibble <= rx_second_q;
            rx_word_sync <= ~rx_fmt_q[`FDNP_FMT_SYNCINV];
            rx_phase_q <= FDNP_RX_FIRST;
          end
        endcase
      end
    end
  end

  // Serial register port: 8-bit header (read flag, address) then 8 data bits
  fdnp_spi_state_type spi_state_q;
  logic [2:0] spi_cnt_q;
  logic [7:0] spi_head_q;
  logic [7:0] spi_shift_q;
  logic sclk_prev_q;
  logic spi_wr_q; // One-cycle write commit
  logic [7:0] spi_rd_data;
  logic sclk_rise;
  logic sclk_fall;
  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;

  // Readback mux; unmapped offsets read zero
  always_comb begin
    unique case (spi_head_q[4:0])
      `FDNP_OFS_CLK_CTRL: spi_rd_data = clk_ctrl_q;
      `FDNP_OFS_RX_GAIN: spi_rd_data = gain_en_q ? {2'b01, rx_gain_q} : 8'h00;
      `FDNP_OFS_GAIN_SRC: spi_rd_data = gain_src_q;
      `FDNP_OFS_TX_FMT: spi_rd_data = tx_fmt_q;
      `FDNP_OFS_RX_FMT: spi_rd_data = rx_fmt_q;
      `FDNP_OFS_DRIVE: spi_rd_data = drive_q;
      default: spi_rd_data = 8'h00;
    endcase
  end

  // Frame sequencing and shifting
  always_ff @(posedge clk) begin
    if (reset) begin
      spi_state_q <= FDNP_SPI_IDLE;
      spi_cnt_q <= 3'h0;
      spi_head_q <= 8'h00;
      spi_shift_q <= 8'h00;
      sclk_prev_q <= 1'b0;
      spi_wr_q <= 1'b0;
      spi_sdo <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      spi_wr_q <= 1'b0;
      if (sen_s) begin
        // Enable high aborts any frame
        spi_state_q <= FDNP_SPI_IDLE;
        spi_cnt_q <= 3'h0;
        spi_sdo_oe <= 1'b0;
      end else begin
        unique case (spi_state_q)
          FDNP_SPI_IDLE: begin
            spi_state_q <= FDNP_SPI_HEAD;
            spi_cnt_q <= 3'h0;
          end
          FDNP_SPI_HEAD: begin
            if (sclk_rise) begin
              spi_head_q <= {spi_head_q[6:0], sdi_s};
              spi_cnt_q <= spi_cnt_q + 3'h1;
              if (spi_cnt_q == 3'h7) begin
                spi_state_q <= FDNP_SPI_DATA;
              end
            end
          end
          FDNP_SPI_DATA: begin
            if (spi_head_q[7]) begin
              // Read: first bit leaves on the fall after the header
              if (sclk_fall) begin
                if (!spi_sdo_oe) begin
                  spi_sdo <= spi_rd_data[7];
                  spi_shift_q <= {spi_rd_data[6:0], 1'b0};
                end else begin
                  spi_sdo <= spi_shift_q[7];
                  spi_shift_q <= {spi_shift_q[6:0], 1'b0};
                end
                spi_sdo_oe <= 1'b1;
              end
            end else if (sclk_rise) begin
              spi_shift_q <= {spi_shift_q[6:0], sdi_s};
              spi_cnt_q <= spi_cnt_q + 3'h1;
              if (spi_cnt_q == 3'h7) begin
                spi_wr_q <= 1'b1;
                spi_state_q <= FDNP_SPI_HEAD; // Further bytes start a new header
              end
            end
          end
          default: spi_state_q <= FDNP_SPI_IDLE;
        endcase
      end
    end
  end

  // Configuration register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      clk_ctrl_q <= `FDNP_RST_CLK_CTRL;
      gain_src_q <= `FDNP_RST_GAIN_SRC;
      tx_fmt_q <= `FDNP_RST_FMT;
      rx_fmt_q <= `FDNP_RST_FMT;
      drive_q <= `FDNP_RST_DRIVE;
      gain_en_q <= 1'b0;
    end else if (spi_wr_q) begin
      unique case (spi_head_q[4:0])
        `FDNP_OFS_CLK_CTRL: clk_ctrl_q <= spi_shift_q;
        `FDNP_OFS_RX_GAIN: gain_en_q <= spi_shift_q[`FDNP_GAIN_EN];
        `FDNP_OFS_GAIN_SRC: gain_src_q <= spi_shift_q;
        `FDNP_OFS_TX_FMT: tx_fmt_q <= spi_shift_q;
        `FDNP_OFS_RX_FMT: rx_fmt_q <= spi_shift_q;
        `FDNP_OFS_DRIVE: drive_q <= spi_shift_q;
        default: ;
      endcase
    end
  end

  // Gain registers: port selection beats the transmit bus, which beats serial writes
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_gain_q <= `FDNP_RST_GAIN; // Minimum gain code
      tx_gain_q <= `FDNP_RST_GAIN;
    end else begin
      if (gain_src_q[`FDNP_SRC_PORT_RX]) begin
        rx_gain_q <= gport_s; // Direct pass, no strobe
      end else if (tx_gain_load) begin
        rx_gain_q <= txn_s;
      end else if (spi_wr_q && spi_head_q[4:0] == `FDNP_OFS_RX_GAIN && spi_shift_q[`FDNP_GAIN_EN]) begin
        rx_gain_q <= spi_shift_q[5:0];
      end
      if (gain_src_q[`FDNP_SRC_PORT_TX]) begin
        tx_gain_q <= gport_s;
      end
    end
  end

  // Registered gain and drive outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      receive_gain_amp <= `FDNP_RST_GAIN;
      transmit_gain_amp <= `FDNP_RST_GAIN;
      low_drive <= 1'b0;
    end else begin
      receive_gain_amp <= rx_gain_q;
      transmit_gain_amp <= tx_gain_q;
      low_drive <= drive_q[7];
    end
  end
endmodule : fdnp_port

`default_nettype wire

//--- fdnp_host_model.sv
// Host-side model of the nibble port: drives transmit nibbles, collects receive words.
// Assumes it faces fdnp_port pin to pin and is steered by the bench through its tasks.
`default_nettype none
module fdnp_host_model (
  input wire logic port_clock_out,
  input wire logic [5:0] rx_nibble,
  input wire logic rx_word_sync,
  output logic [5:0] tx_nibble,
  output logic tx_word_sync
);
  timeunit 1ns;
  timeprecision 100ps;
  logic neg_edge = 1'b0; // Device samples on the falling pin edge
  logic [5:0] ms_q = 6'h00; // First receive nibble awaiting its partner
  logic [9:0] rx_last = 10'h000; // Last receive word put together
  int rx_count = 0; // Receive words seen
  initial begin
    tx_nibble = 6'h2a;
    tx_word_sync = 1'b1;
  end
  // Change on the edge opposite the sampling one, so a full half period of setup is left
  task automatic send_nib(input logic [5:0] n, input logic s);
    if (neg_edge) begin
      @(posedge port_clock_out);
    end else begin
      @(negedge port_clock_out);
    end
    #1; // Pins move just after the clock edge, never on it
    tx_nibble = n;
    tx_word_sync = s;
  endtask : send_nib
  // Released bus: sync sits at the second level and data flips, so nothing stale reads well
  task automatic release_bus(input logic s);
    send_nib(~tx_nibble, s);
  endtask : release_bus
  // Receive nibbles are taken on the rising pin edge, first level is the upper part
  always @(posedge port_clock_out) begin
    if (rx_word_sync === 1'b0) begin
      ms_q <= rx_nibble;
    end else begin
      rx_last <= {ms_q, rx_nibble[3:0]};
      rx_count <= rx_count + 1;
    end
  end
endmodule : fdnp_host_model
`default_nettype wire

//--- fdnp_port_chk.sv
// Pin-level checks of the full-duplex nibble port.
// Assumes default receive format and serial clock levels of at least four cycles.
`default_nettype none
module fdnp_port_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic mode_strap,
  input wire logic tx_quiet_n,
  input wire logic port_clock_out,
  input wire logic [5:0] rx_nibble,
  input wire logic rx_nibble_oe,
  input wire logic rx_word_sync,
  input wire logic [9:0] tx_word,
  input wire logic tx_word_valid,
  input wire logic tx_output_enable,
  input wire logic rx_word_take,
  input wire logic spi_sclk,
  input wire logic spi_sen_n,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Two nibbles per word, so words come at most every two port clock periods
  a_word_space: assert property (tx_word_valid |=> !tx_word_valid [*8])
    else $error("transmit words too close");
  a_take_space: assert property (rx_word_take |=> !rx_word_take [*8])
    else $error("receive words taken too close");
  a_quiet_follow: assert property (!tx_quiet_n |-> ##[1:4] !tx_output_enable)
    else $error("quiet input ignored");
  a_quiet_word: assert property (
    tx_word_valid && !tx_output_enable && !$past(tx_output_enable, 3) |-> tx_word == 10'h000)
    else $error("word not suppressed while quiet");
  // Receive bus must not move at the validating pin edge
  a_rx_settled: assert property ($rose(port_clock_out) |-> $stable(rx_nibble) && $stable(rx_word_sync))
    else $error("receive nibble moved at rising clock");
  a_sync_hold: assert property ($changed(rx_word_sync) && rx_nibble_oe |=> $stable(rx_word_sync) [*5])
    else $error("receive sync toggled too fast");
  a_sdo_release: assert property ($rose(spi_sen_n) |-> ##[0:4] !spi_sdo_oe)
    else $error("serial output kept after frame");
  a_sdo_frame: assert property ($rose(spi_sdo_oe) |-> !spi_sen_n)
    else $error("serial output outside frame");
  a_sdo_edge: assert property (spi_sdo_oe && $changed(spi_sdo) |-> !spi_sclk)
    else $error("serial data changed while clock high");
  a_mode_off: assert property (!mode_strap |-> ##[1:4] !rx_nibble_oe)
    else $error("receive bus driven with strap low");
  a_clock_off: assert property (!mode_strap [*4] |-> !port_clock_out)
    else $error("port clock runs with strap low");
endmodule : fdnp_port_chk
bind fdnp_port fdnp_port_chk fdnp_port_chk_i (.clk(clk), .reset(reset), .mode_strap(mode_strap),
  .tx_quiet_n(tx_quiet_n), .port_clock_out(port_clock_out), .rx_nibble(rx_nibble), .rx_nibble_oe(rx_nibble_oe),
  .rx_word_sync(rx_word_sync), .tx_word(tx_word), .tx_word_valid(tx_word_valid),
  .tx_output_enable(tx_output_enable), .rx_word_take(rx_word_take), .spi_sclk(spi_sclk),
  .spi_sen_n(spi_sen_n), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));
`default_nettype wire

//--- tb_fdnp_port.sv
// Self-checking bench for the full-duplex nibble port.
// Assumes the port, its header, the host model and the checker are compiled first.
`default_nettype none
`define CHK(a, e) begin \
  checked++; \
  if ((a) !== (e)) begin \
    fails++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); \
  end \
end
module tb_fdnp_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, reset = 1'b1, mode_strap = 1'b1, oscillator_input = 1'b1, tx_quiet_n = 1'b1;
  logic gain_strobe = 1'b0, spi_sclk = 1'b0, spi_sen_n = 1'b1, spi_sdi = 1'b0;
  logic [5:0] gain_word_port = 6'h00;
  logic [9:0] rx_word = 10'h1b6; // Converter word, clk domain
  logic port_clock_out, rx_nibble_oe, rx_word_sync, tx_word_valid, tx_output_enable, rx_word_take;
  logic low_drive, spi_sdo, spi_sdo_oe, tx_word_sync;
  logic [5:0] tx_nibble, rx_nibble, receive_gain_amp, transmit_gain_amp;
  logic [9:0] tx_word, last_tx = 10'h000;
  logic [7:0] rd = 8'h00; // Last serial read byte
  int fails = 0, checked = 0, nvalid = 0;
  fdnp_port fdnp_port_i (.clk(clk), .reset(reset), .mode_strap(mode_strap), .oscillator_input(oscillator_input),
    .port_clock_out(port_clock_out), .tx_nibble(tx_nibble), .tx_word_sync(tx_word_sync), .tx_quiet_n(tx_quiet_n),
    .gain_strobe(gain_strobe), .gain_word_port(gain_word_port), .rx_nibble(rx_nibble), .rx_nibble_oe(rx_nibble_oe),
    .rx_word_sync(rx_word_sync), .tx_word(tx_word), .tx_word_valid(tx_word_valid),
    .tx_output_enable(tx_output_enable), .rx_word(rx_word), .rx_word_take(rx_word_take),
    .receive_gain_amp(receive_gain_amp), .transmit_gain_amp(transmit_gain_amp), .low_drive(low_drive),
    .spi_sclk(spi_sclk), .spi_sen_n(spi_sen_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));
  fdnp_host_model fdnp_host_model_i (.port_clock_out(port_clock_out), .rx_nibble(rx_nibble),
    .rx_word_sync(rx_word_sync), .tx_nibble(tx_nibble), .tx_word_sync(tx_word_sync));
  initial begin
    forever #25 clk = ~clk;
  end
  // Count assembled words; the pulse lasts one cycle so it is caught on exactly one edge
  always @(posedge clk) begin
    if (tx_word_valid === 1'b1) begin
      nvalid <= nvalid + 1;
      last_tx <= tx_word;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic stop_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  // One serial frame, header then data; four-cycle levels clear the synchroniser with margin
  task automatic spi(input logic [7:0] head, input logic [7:0] data);
    logic [15:0] f;
    f = {head, data};
    spi_sen_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi = f[i];
      tick(4);
      if (i < 8) rd[i] = spi_sdo;
      spi_sclk = 1'b1;
      tick(4);
      spi_sclk = 1'b0;
    end
    tick(2);
    spi_sen_n = 1'b1;
    tick(6);
  endtask : spi
  // Send one word as two nibbles, first at level s, and check what the device assembled
  task automatic tx_check(input logic [5:0] a, input logic [5:0] b, input logic s, input logic [9:0] e);
    int n;
    n = nvalid;
    fdnp_host_model_i.send_nib(a, s);
    fdnp_host_model_i.send_nib(b, ~s);
    fdnp_host_model_i.release_bus(~s);
    tick(2);
    `CHK(nvalid, n + 1)
    `CHK(last_tx, e)
  endtask : tx_check
  task automatic t_regs();
    logic [4:0] a[7] = '{5'h05, 5'h09, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h1f};
    logic [7:0] v[7] = '{8'h00, 8'h00, 8'h04, 8'h01, 8'h01, 8'h00, 8'h00};
    `CHK(receive_gain_amp, 6'h00)
    for (int i = 0; i < 7; i++) begin
      spi({3'b100, a[i]}, 8'h00);
      `CHK(rd, v[i])
    end
    spi(8'h0e, 8'h80);
    `CHK(low_drive, 1'b1)
    spi(8'h1f, 8'hff);
    spi(8'h9f, 8'h00);
    `CHK(rd, 8'h00)
    spi(8'h0e, 8'h00);
    $display("regs done");
  endtask : t_regs
  // Default, 5/5 binary, inverted sync with low part first, falling edge, then a long first level
  task automatic t_tx();
    int n;
    tx_check(6'h2a, 6'h05, 1'b0, 10'h2a5);
    tx_check(6'h15, 6'h3c, 1'b0, 10'h15c);
    spi(8'h0c, 8'h08);
    tx_check(6'h2b, 6'h0f, 1'b0, 10'h0a7);
    spi(8'h0c, 8'h15);
    tx_check(6'h09, 6'h31, 1'b1, 10'h319);
    spi(8'h0c, 8'h03);
    fdnp_host_model_i.neg_edge = 1'b1;
    tx_check(6'h1d, 6'h06, 1'b0, 10'h1d6);
    fdnp_host_model_i.neg_edge = 1'b0;
    spi(8'h0c, 8'h01);
    n = nvalid;
    fdnp_host_model_i.send_nib(6'h11, 1'b0);
    fdnp_host_model_i.send_nib(6'h22, 1'b0);
    `CHK(nvalid, n)
    tx_check(6'h33, 6'h04, 1'b0, 10'h334);
    $display("tx done");
  endtask : t_tx
  // Receive format fmt, converter word w, word e expected at the host after sign handling
  task automatic t_rx(input logic [7:0] fmt, input logic [9:0] w, input logic [9:0] e);
    int n;
    spi(8'h0d, fmt);
    n = fdnp_host_model_i.rx_count;
    rx_word = w;
    for (int i = 0; i < 100 && fdnp_host_model_i.rx_count < n + 3; i++) tick(1);
    if (fdnp_host_model_i.rx_count < n + 3) begin
      fails++;
      stop_test();
    end
    `CHK(fdnp_host_model_i.rx_last, e)
    `CHK(rx_nibble_oe, 1'b1)
    $display("rx done");
  endtask : t_rx
  // Serial, transmit-bus and dedicated-port gain paths
  task automatic t_gain();
    spi(8'h09, 8'h15);
    `CHK(receive_gain_amp, 6'h00)
    spi(8'h09, 8'h7c);
    `CHK(receive_gain_amp, 6'h3c)
    spi(8'h89, 8'h00);
    `CHK(rd, 8'h7c)
    gain_strobe = 1'b1;
    fdnp_host_model_i.send_nib(6'h2c, 1'b0);
    fdnp_host_model_i.release_bus(1'b1);
    gain_strobe = 1'b0;
    tick(8);
    `CHK(receive_gain_amp, 6'h2c)
    // Software strobe stands in for the pin, which stays low
    spi(8'h0b, 8'h0c);
    fdnp_host_model_i.send_nib(6'h15, 1'b0);
    fdnp_host_model_i.release_bus(1'b1);
    spi(8'h0b, 8'h04);
    `CHK(receive_gain_amp, 6'h15)
    spi(8'h0b, 8'h24);
    gain_word_port = 6'h1b;
    tick(6);
    `CHK(receive_gain_amp, 6'h1b)
    spi(8'h0b, 8'h44);
    gain_word_port = 6'h17;
    tick(6);
    `CHK(transmit_gain_amp, 6'h17)
    `CHK(receive_gain_amp, 6'h1b)
    spi(8'h0b, 8'h04);
    $display("gain done");
  endtask : t_gain
  task automatic t_clock();
    int hi;
    hi = 0;
    for (int i = 0; i < 40; i++) begin
      tick(1);
      if (port_clock_out === 1'b1) hi++;
    end
    `CHK(hi, 20)
    spi(8'h05, 8'h01);
    `CHK(port_clock_out, 1'b0)
    spi(8'h05, 8'h04);
    `CHK(port_clock_out, 1'b1)
    oscillator_input = 1'b0;
    tick(6);
    `CHK(port_clock_out, 1'b0)
    spi(8'h05, 8'h06);
    `CHK(port_clock_out, 1'b1)
    oscillator_input = 1'b1;
    spi(8'h05, 8'h00);
    $display("clock done");
  endtask : t_clock
  // Quiet suppression, a half word cut by reset, and the mode strap
  task automatic t_misc();
    int n;
    tx_quiet_n = 1'b0;
    tick(6);
    `CHK(tx_output_enable, 1'b0)
    tx_check(6'h2a, 6'h05, 1'b0, 10'h000);
    tx_quiet_n = 1'b1;
    tick(6);
    `CHK(tx_output_enable, 1'b1)
    n = nvalid;
    // Second nibble reaches the pins as reset starts, so only a kept first nibble could pair with it
    fdnp_host_model_i.send_nib(6'h2e, 1'b0);
    fdnp_host_model_i.send_nib(6'h07, 1'b1);
    reset = 1'b1;
    tick(3);
    reset = 1'b0;
    fdnp_host_model_i.release_bus(1'b1);
    `CHK(nvalid, n)
    `CHK(receive_gain_amp, 6'h00)
    mode_strap = 1'b0;
    tick(8);
    `CHK(rx_nibble_oe, 1'b0)
    mode_strap = 1'b1;
    tick(8);
    `CHK(rx_nibble_oe, 1'b1)
    spi(8'h0d, 8'h21);
    `CHK(rx_nibble_oe, 1'b0)
    spi(8'h0d, 8'h01);
    `CHK(rx_nibble_oe, 1'b1)
    $display("misc done");
  endtask : t_misc
  initial begin
    tick(20);
    reset = 1'b0;
    tick(6);
    t_regs();
    t_tx();
    t_rx(8'h01, 10'h1b6, 10'h1b6);
    t_rx(8'h01, 10'h2c3, 10'h2c3);
    t_rx(8'h00, 10'h2c3, 10'h0c3);
    t_gain();
    t_clock();
    t_misc();
    stop_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    stop_test();
  end
endmodule : tb_fdnp_port
`default_nettype wire
